// *** logic/pomm_top.sv ***
// Purpose: Mailbox interpreter that builds the parameter output attribute map.
// Assumes: Inputs come from logic on CLK; one idle cycle follows each last word.
// Notes: The reply trails the request by one word so an offset can be zeroed late.
`timescale 1ns/1ns
`default_nettype none
module pomm_top
  import pomm_pkg::*;
(
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    MBX_VALID,
  input  wire logic [15:0]             MBX_DATA,
  input  wire logic                    MBX_LAST,
  output var  logic                    REP_VALID,
  output var  logic [15:0]             REP_DATA,
  output var  logic                    REP_LAST,
  output var  logic                    REP_ACCEPT,
  input  wire logic                    ACC_REQ,
  input  wire logic                    ACC_SET,
  input  wire logic [5:0]              ACC_ATTR,
  input  wire logic [15:0]             ACC_BYTE,
  input  wire logic [7:0]              ACC_WDATA,
  output var  logic                    ACC_ACK,
  output var  logic                    ACC_ERR,
  output var  logic [7:0]              ACC_RDATA,
  output var  logic [15:0]             ACC_LEN,
  input  wire logic [POMM_AREA_AW-1:0] APP_ADDR,
  output var  logic [7:0]              APP_RDATA
);
  logic [7:0]  widx_reg, widx_next;
  logic        acc_reg, acc_next;
  logic        fin_reg, fin_next;
  logic [15:0] hold_reg, hold_next;
  logic        hvld_reg, hvld_next;
  logic        hlast_reg, hlast_next;
  logic [15:0] poff_reg, poff_next;
  logic        rvld_reg, rvld_next;
  logic [15:0] rdat_reg, rdat_next;
  logic        rlast_reg, rlast_next;
  logic        racc_reg, racc_next;
  logic [49:0] map_reg, map_next;
  logic [15:0] off_reg [0:49];
  logic [15:0] off_next [0:49];
  logic [15:0] len_reg [0:49];
  logic [15:0] len_next [0:49];
  logic        ack_reg, ack_next;
  logic        err_reg, err_next;
  logic [15:0] alen_reg, alen_next;
  logic [7:0]  k;
  logic [5:0]  slot;
  logic [15:0] wdat;
  logic        zero_prev;
  logic        pair_ok;
  logic [5:0]  sel;
  logic        hit;
  logic        area_we;
  logic [POMM_AREA_AW-1:0] area_addr;
  logic [15:0] byte_pos;

  // Mailbox word stream, map table and reply stream.
  always_comb begin
    widx_next  = widx_reg;
    acc_next   = acc_reg;
    fin_next   = fin_reg;
    hold_next  = hold_reg;
    hvld_next  = hvld_reg;
    hlast_next = hlast_reg;
    poff_next  = poff_reg;
    rvld_next  = 1'b0;
    rdat_next  = rdat_reg;
    rlast_next = 1'b0;
    racc_next  = racc_reg;
    map_next   = map_reg;
    off_next   = off_reg;
    len_next   = len_reg;
    k          = widx_reg - POMM_HDR_WORDS;
    slot       = k[6:1];
    wdat       = MBX_DATA;
    zero_prev  = 1'b0;
    pair_ok    = (MBX_DATA != 16'h0000) &&
                 ({1'b0, poff_reg} + {1'b0, MBX_DATA} <= POMM_AREA_BYTES);
    if (MBX_VALID) begin
      widx_next = (widx_reg == 8'hff) ? widx_reg : widx_reg + 8'h01;
      if (widx_reg == POMM_IDX_INFO) begin
        wdat = POMM_REP_INFO;
        if (MBX_DATA != POMM_REQ_INFO) begin
          acc_next = 1'b0;
        end
      end else if (widx_reg == POMM_IDX_CMD) begin
        if (MBX_DATA != POMM_CMD_NUM) begin
          acc_next = 1'b0;
        end
      end else if (widx_reg == POMM_IDX_SIZE) begin
        // Anything past fifty pairs or half a pair is refused whole.
        if (MBX_DATA > POMM_MAX_BYTES || MBX_DATA[1:0] != 2'b00) begin
          acc_next = 1'b0;
        end
      end else if (widx_reg == POMM_IDX_FCNT || widx_reg == POMM_IDX_FNUM) begin
        if (MBX_DATA != POMM_ONE_FRAME) begin
          acc_next = 1'b0;
        end
      end
      // The old map is dropped once the header is known good.
      if (widx_reg == POMM_HDR_WORDS - 8'h01 && acc_reg) begin
        map_next = '0;
      end
      if (widx_reg >= POMM_HDR_WORDS) begin
        if (!k[0]) begin
          poff_next = MBX_DATA;
        end else if (acc_reg && slot < POMM_MAX_ATTR) begin
          map_next[slot] = pair_ok;
          off_next[slot] = poff_reg;
          len_next[slot] = MBX_DATA;
          if (!pair_ok) begin
            wdat      = 16'h0000;
            zero_prev = 1'b1;
          end
        end
      end
      if (hvld_reg) begin
        rvld_next = 1'b1;
        rdat_next = zero_prev ? 16'h0000 : hold_reg;
      end
      hold_next  = wdat;
      hvld_next  = 1'b1;
      hlast_next = MBX_LAST;
      if (MBX_LAST) begin
        fin_next  = acc_next;
        acc_next  = 1'b1;
        widx_next = 8'h00;
      end
    end else if (hvld_reg && hlast_reg) begin
      rvld_next  = 1'b1;
      rdat_next  = hold_reg;
      rlast_next = 1'b1;
      racc_next  = fin_reg;
      hvld_next  = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      widx_reg  <= 8'h00;
      acc_reg   <= 1'b1;
      fin_reg   <= 1'b0;
      hold_reg  <= 16'h0000;
      hvld_reg  <= 1'b0;
      hlast_reg <= 1'b0;
      poff_reg  <= 16'h0000;
      rvld_reg  <= 1'b0;
      rdat_reg  <= 16'h0000;
      rlast_reg <= 1'b0;
      racc_reg  <= 1'b0;
      map_reg   <= '0;
      for (int i = 0; i < 50; i++) begin
        off_reg[i] <= 16'h0000;
        len_reg[i] <= 16'h0000;
      end
    end else begin
      widx_reg  <= widx_next;
      acc_reg   <= acc_next;
      fin_reg   <= fin_next;
      hold_reg  <= hold_next;
      hvld_reg  <= hvld_next;
      hlast_reg <= hlast_next;
      poff_reg  <= poff_next;
      rvld_reg  <= rvld_next;
      rdat_reg  <= rdat_next;
      rlast_reg <= rlast_next;
      racc_reg  <= racc_next;
      map_reg   <= map_next;
      off_reg   <= off_next;
      len_reg   <= len_next;
    end
  end

  // Single-attribute access from the fieldbus master, one byte per request.
  always_comb begin
    sel       = (ACC_ATTR != 6'h00 && ACC_ATTR <= POMM_MAX_ATTR) ? ACC_ATTR - 6'h01 : 6'h00;
    hit       = ACC_REQ && ACC_ATTR != 6'h00 && ACC_ATTR <= POMM_MAX_ATTR &&
                map_reg[sel] && ACC_BYTE < len_reg[sel];
    byte_pos  = off_reg[sel] + ACC_BYTE;
    area_addr = byte_pos[POMM_AREA_AW-1:0];
    area_we   = hit && ACC_SET;
    ack_next  = ACC_REQ;
    err_next  = ACC_REQ && !hit;
    // The length stands from one request to the next, as the master may read it late.
    alen_next = alen_reg;
    if (ACC_REQ) begin
      alen_next = hit ? len_reg[sel] : 16'h0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      alen_reg <= 16'h0000;
    end else begin
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      alen_reg <= alen_next;
    end
  end

  pomm_area u_area (
    .clk     (CLK),
    .a_we    (area_we),
    .a_addr  (area_addr),
    .a_wdata (ACC_WDATA),
    .a_rdata (ACC_RDATA),
    .b_addr  (APP_ADDR),
    .b_rdata (APP_RDATA)
  );

  assign REP_VALID  = rvld_reg;
  assign REP_DATA   = rdat_reg;
  assign REP_LAST   = rlast_reg;
  assign REP_ACCEPT = racc_reg;
  assign ACC_ACK    = ack_reg;
  assign ACC_ERR    = err_reg;
  assign ACC_LEN    = alen_reg;
endmodule : pomm_top
`default_nettype wire

// *** logic/pomm_pkg.sv ***
// Purpose: Constants for the parameter output map mailbox block.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes: Mailbox words are 16 bits and the parameter output area is byte wide.
package pomm_pkg;
  localparam logic [7:0]  POMM_CLASS_CODE = 8'hb1;
  localparam logic [5:0]  POMM_MAX_ATTR   = 6'h32;
  localparam logic [7:0]  POMM_IDX_INFO   = 8'h01;
  localparam logic [7:0]  POMM_IDX_CMD    = 8'h02;
  localparam logic [7:0]  POMM_IDX_SIZE   = 8'h03;
  localparam logic [7:0]  POMM_IDX_FCNT   = 8'h04;
  localparam logic [7:0]  POMM_IDX_FNUM   = 8'h05;
  localparam logic [7:0]  POMM_HDR_WORDS  = 8'h10;
  localparam logic [15:0] POMM_REQ_INFO   = 16'h4002;
  localparam logic [15:0] POMM_REP_INFO   = 16'h0002;
  localparam logic [15:0] POMM_CMD_NUM    = 16'h0005;
  localparam logic [15:0] POMM_ONE_FRAME  = 16'h0001;
  localparam logic [15:0] POMM_MAX_BYTES  = 16'h00c8;
  localparam logic [16:0] POMM_AREA_BYTES = 17'h00100;
  localparam int          POMM_AREA_AW    = 8;
endpackage : pomm_pkg

// *** logic/pomm_area.sv ***
// Purpose: Byte store for the parameter data output area.
// Assumes: Single clock; contents are not reset.
// Notes: Port A serves the fieldbus master, port B the gateway application.
`timescale 1ns/1ns
`default_nettype none
module pomm_area
  import pomm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    a_we,
  input  wire logic [POMM_AREA_AW-1:0] a_addr,
  input  wire logic [7:0]              a_wdata,
  output var  logic [7:0]              a_rdata,
  input  wire logic [POMM_AREA_AW-1:0] b_addr,
  output var  logic [7:0]              b_rdata
);
  logic [7:0] mem [0:(1<<POMM_AREA_AW)-1];

  // Read data is registered so both ports leave the top straight from a flip-flop.
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule : pomm_area
`default_nettype wire

// *** sim/pomm_checker.sv ***
// Purpose: Port checks for pomm_top.
// Assumes: One clock, SYS_RST synchronous and active high.
// Notes: Bound to every pomm_top instance.
`timescale 1ns/1ns
`default_nettype none
module pomm_checker
  import pomm_pkg::*;
(
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        MBX_VALID,
  input wire logic        MBX_LAST,
  input wire logic        REP_VALID,
  input wire logic        REP_LAST,
  input wire logic        REP_ACCEPT,
  input wire logic        ACC_REQ,
  input wire logic        ACC_ACK,
  input wire logic        ACC_ERR,
  input wire logic [15:0] ACC_LEN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_ack_follows: assert property (ACC_REQ |=> ACC_ACK) else $error("ack missing");
  a_ack_no_req: assert property (!ACC_REQ |=> !ACC_ACK) else $error("stray ack");
  a_err_len_zero: assert property (ACC_ACK && ACC_ERR |-> ACC_LEN == 16'h0000)
    else $error("length on error");
  a_ok_len_set: assert property (ACC_ACK && !ACC_ERR |-> ACC_LEN != 16'h0000)
    else $error("empty attribute served");
  a_len_stands: assert property (!ACC_ACK |-> $stable(ACC_LEN))
    else $error("len moved");
  a_reply_ends: assert property (MBX_VALID && MBX_LAST |-> ##[1:3] (REP_VALID && REP_LAST))
    else $error("reply end missing");
  a_last_valid: assert property (REP_LAST |-> REP_VALID) else $error("lone last");
  a_accept_holds: assert property (!REP_LAST |-> $stable(REP_ACCEPT))
    else $error("accept moved");
endmodule : pomm_checker
bind pomm_top pomm_checker pomm_checker_inst (.CLK, .SYS_RST, .MBX_VALID, .MBX_LAST,
  .REP_VALID, .REP_LAST, .REP_ACCEPT, .ACC_REQ, .ACC_ACK, .ACC_ERR, .ACC_LEN);
`default_nettype wire

// *** sim/pomm_app_model.sv ***
// Purpose: Configuring application that sends mailbox words.
// Assumes: Words change just after a rising edge.
// Notes: Released data shows the inverse so stale words are not read as good.
`timescale 1ns/1ns
`default_nettype none
module pomm_app_model (
  input  wire logic        clk,
  output var  logic        mbx_valid,
  output var  logic [15:0] mbx_data,
  output var  logic        mbx_last
);
  initial begin
    mbx_valid = 1'b0;
    mbx_data  = 16'h0000;
    mbx_last  = 1'b0;
  end
  task automatic send(input logic [15:0] w[$]);
    for (int i = 0; i < w.size(); i++) begin
      @(posedge clk);
      mbx_valid <= 1'b1;
      mbx_data  <= w[i];
      mbx_last  <= (i == w.size() - 1);
    end
    @(posedge clk);
    mbx_valid <= 1'b0;
    mbx_last  <= 1'b0;
    mbx_data  <= ~mbx_data;
    @(posedge clk);
  endtask : send
endmodule : pomm_app_model
`default_nettype wire

// *** sim/tb_pomm_top.sv ***
// Purpose: Self-checking bench for pomm_top.
// Assumes: Area bytes are written before they are read back.
// Notes: Expected replies are rebuilt from the request words.
`timescale 1ns/1ns
`default_nettype none
module tb_pomm_top;
  import pomm_pkg::*;
  logic        CLK = 1'b0, SYS_RST = 1'b1, ACC_REQ = 1'b0, ACC_SET = 1'b0;
  logic [5:0]  ACC_ATTR = 6'h00;
  logic [15:0] ACC_BYTE = 16'h0000, MBX_DATA, REP_DATA, ACC_LEN;
  logic [7:0]  ACC_WDATA = 8'h00, APP_ADDR = 8'h00, ACC_RDATA, APP_RDATA;
  logic        MBX_VALID, MBX_LAST, REP_VALID, REP_LAST, REP_ACCEPT, ACC_ACK, ACC_ERR;
  logic [15:0] pr[$], rq[$];
  int          errors = 0, cmp_count = 0, cyc = 0, nl = 0;
  logic        lst = 1'b0;
  pomm_top pomm_top_inst (.CLK, .SYS_RST, .MBX_VALID, .MBX_DATA, .MBX_LAST, .REP_VALID,
    .REP_DATA, .REP_LAST, .REP_ACCEPT, .ACC_REQ, .ACC_SET, .ACC_ATTR, .ACC_BYTE, .ACC_WDATA,
    .ACC_ACK, .ACC_ERR, .ACC_RDATA, .ACC_LEN, .APP_ADDR, .APP_RDATA);
  pomm_app_model pomm_app_model_inst (.clk(CLK), .mbx_valid(MBX_VALID), .mbx_data(MBX_DATA),
    .mbx_last(MBX_LAST));
  initial forever #2 CLK = ~CLK;
  always @(posedge CLK) begin
    if (REP_VALID === 1'b1) begin
      rq.push_back(REP_DATA);
      lst <= REP_LAST;
      if (REP_LAST === 1'b1) nl <= nl + 1;
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic [15:0] cmd, input logic [15:0] info, input int bad,
    input logic ok);
    logic [15:0] w[$];
    w = {16'h0001, info, cmd, 16'(pr.size() * 2), 16'h0001, 16'h0001};
    repeat (10) w.push_back(16'h0000);
    w = {w, pr};
    rq = {};
    nl = 0;
    pomm_app_model_inst.send(w);
    for (int i = 0; i < 8 && rq.size() < w.size(); i++) begin
      @(posedge CLK);
      #1;
    end
    w[1] = POMM_REP_INFO;
    if (bad >= 0) w[16 + 2 * bad] = 16'h0000;
    if (bad >= 0) w[17 + 2 * bad] = 16'h0000;
    chk("reply size", 16'(rq.size()), 16'(w.size()));
    for (int i = 0; i < w.size(); i++) chk("reply word", rq[i], w[i]);
    chk("reply last", {15'h0000, lst}, 16'h0001);
    chk("last count", 16'(nl), 16'h0001);
    chk("accept", {15'h0000, REP_ACCEPT}, {15'h0000, ok});
  endtask : run
  task automatic acc(input logic s, input logic [5:0] a, input logic [15:0] b,
    input logic [7:0] d, input logic err, input logic [15:0] len);
    @(posedge CLK);
    ACC_REQ   <= 1'b1;
    ACC_SET   <= s;
    ACC_ATTR  <= a;
    ACC_BYTE  <= b;
    ACC_WDATA <= d;
    @(posedge CLK);
    ACC_REQ <= 1'b0;
    // The acknowledge stands for this one cycle only, so it is judged now.
    #1;
    chk("ack", {15'h0000, ACC_ACK}, 16'h0001);
    chk("err", {15'h0000, ACC_ERR}, {15'h0000, err});
    chk("len", ACC_LEN, len);
    if (!s && !err) chk("rdata", {8'h00, ACC_RDATA}, {8'h00, d});
  endtask : acc
  task automatic app(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    APP_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1;
    chk("area", {8'h00, APP_RDATA}, {8'h00, d});
  endtask : app
  task automatic t_map();
    pr = {16'h0000, 16'h0006, 16'h0000, 16'h0000, 16'h000a, 16'h0004,
          16'h00fa, 16'h000a, 16'h00ff, 16'h0001};
    run(POMM_CMD_NUM, POMM_REQ_INFO, 3, 1'b1);
    for (int i = 0; i < 6; i++) acc(1'b1, 6'h01, 16'(i), 8'(8'ha0 + i), 1'b0, 16'h0006);
    for (int i = 0; i < 6; i++) acc(1'b0, 6'h01, 16'(i), 8'(8'ha0 + i), 1'b0, 16'h0006);
    app(8'h03, 8'ha3);
    acc(1'b0, 6'h02, 16'h0000, 8'h00, 1'b1, 16'h0000);
    acc(1'b1, 6'h03, 16'h0001, 8'h5c, 1'b0, 16'h0004);
    app(8'h0b, 8'h5c);
    acc(1'b0, 6'h03, 16'h0004, 8'h00, 1'b1, 16'h0000);
    acc(1'b0, 6'h04, 16'h0000, 8'h00, 1'b1, 16'h0000);
    acc(1'b1, 6'h05, 16'h0000, 8'h77, 1'b0, 16'h0001);
    acc(1'b0, 6'h05, 16'h0000, 8'h77, 1'b0, 16'h0001);
    acc(1'b0, 6'h06, 16'h0000, 8'h00, 1'b1, 16'h0000);
    $display("test map done");
  endtask : t_map
  task automatic t_refuse();
    pr = {16'h0020, 16'h0002};
    run(16'h0004, POMM_REQ_INFO, -1, 1'b0);
    run(POMM_CMD_NUM, 16'h4001, -1, 1'b0);
    pr = {16'h0020, 16'h0002, 16'h0020};
    run(POMM_CMD_NUM, POMM_REQ_INFO, -1, 1'b0);
    pr = {};
    for (int k = 0; k < 51; k++) pr = {pr, 16'h0000, 16'h0001};
    run(POMM_CMD_NUM, POMM_REQ_INFO, -1, 1'b0);
    acc(1'b0, 6'h01, 16'h0002, 8'ha2, 1'b0, 16'h0006);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_full();
    pr = {};
    for (int k = 1; k < 50; k++) pr = {pr, 16'h0000, 16'h0000};
    pr = {pr, 16'h0003, 16'h0001};
    run(POMM_CMD_NUM, POMM_REQ_INFO, -1, 1'b1);
    acc(1'b0, 6'h32, 16'h0000, 8'ha3, 1'b0, 16'h0001);
    acc(1'b0, 6'h01, 16'h0000, 8'h00, 1'b1, 16'h0000);
    $display("test full done");
  endtask : t_full
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_map();
    t_refuse();
    t_full();
    end_sim();
  end
endmodule : tb_pomm_top
`default_nettype wire
